// *** src/pixel_signal_chain_control.sv ***
`timescale 1ns/100ps
module pixel_signal_chain_control #(
   parameter logic [7:0] DEVICE_ID = chain_ctrl_pkg::DEVICE_ID_DEFAULT // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic frame_start_i,
   input wire logic row_start_i,
   input wire logic dark_row_i,
   input wire logic pixel_valid_i,
   input wire logic [8:0] col_i,
   input wire logic row_blue_i,
   input wire logic col_odd_i,
   output logic pixel_valid_o,
   output chain_ctrl_pkg::pixel_ctrl_t pixel_ctrl_o,
   output logic clamp_active_o,
   output logic force_common_mode_o,
   output logic [7:0] upper_converter_reference_o,
   output logic [7:0] lower_converter_reference_o
);
   import chain_ctrl_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [9:0] gain_setting(input logic [9:0] min_v, input logic [9:0] step,
                                               input logic [9:0] max_v, input logic [5:0] code);
      logic [9:0] raw;
      raw = min_v + 10'(code) * step;
      gain_setting = (raw > max_v) ? max_v : raw;
   endfunction

   function automatic logic signed [6:0] offset_value(input logic [5:0] code);
      logic [6:0] mag;
      mag = 7'(code[4:0]) * 7'(OFFSET_STAGE_GAIN);
      offset_value = code[OFFSET_SIGN_BIT] ? -$signed(mag) : $signed(mag);
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   shadow_set_t cfg_q, cfg_d;
   logic col_ctrl_q, col_ctrl_d;
   logic clamp_off_q, clamp_off_d;
   logic [7:0] upper_ref_q, upper_ref_d;
   logic [7:0] lower_ref_q, lower_ref_d;
   logic [7:0] rdata_q, rdata_d;
   clamp_state_t cl_state_q, cl_state_d;
   logic [1:0] dark_cnt_q, dark_cnt_d;
   logic clamp_done_q, clamp_done_d;
   logic clamp_busy;

   always_comb begin
      cfg_d = cfg_q;
      col_ctrl_d = col_ctrl_q;
      clamp_off_d = clamp_off_q;
      upper_ref_d = upper_ref_q;
      lower_ref_d = lower_ref_q;
      rdata_d = rdata_q;
      if (reg_wr_i) begin
         for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == RED_GAIN_OFF + 8'(i)) begin
               cfg_d.colour_gain[i] = reg_wdata_i[5:0];
            end
            if (reg_addr_i == COL_ADDR_BASE_OFF + 8'(i)) begin
               cfg_d.col_addr[i] = reg_wdata_i[5:0];
            end
            if (reg_addr_i == COL_VALUE_BASE_OFF + 8'(i)) begin
               cfg_d.col_value[i] = reg_wdata_i[3:0];
            end
         end
         case (reg_addr_i)
            GLOBAL_GAIN_OFF: cfg_d.global_gain = reg_wdata_i[5:0];
            COL_DC_OFF: cfg_d.col_dc = reg_wdata_i[4:0];
            COL_CTRL_OFF: col_ctrl_d = reg_wdata_i[COL_CTRL_PERCOL_BIT];
            GLOBAL_OFFSET_OFF: cfg_d.global_offset = reg_wdata_i[5:0];
            CAPTURE_MODE_OFF: clamp_off_d = reg_wdata_i[CAPTURE_CLAMP_OFF_BIT];
            UPPER_REF_OFF: upper_ref_d = reg_wdata_i;
            LOWER_REF_OFF: lower_ref_d = reg_wdata_i;
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         rdata_d = 8'h00;
         for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == RED_GAIN_OFF + 8'(i)) begin
               rdata_d = {2'b00, cfg_q.colour_gain[i]};
            end
            if (reg_addr_i == COL_ADDR_BASE_OFF + 8'(i)) begin
               rdata_d = {2'b00, cfg_q.col_addr[i]};
            end
            if (reg_addr_i == COL_VALUE_BASE_OFF + 8'(i)) begin
               rdata_d = {4'h0, cfg_q.col_value[i]};
            end
         end
         case (reg_addr_i)
            GLOBAL_GAIN_OFF: rdata_d = {2'b00, cfg_q.global_gain};
            COL_DC_OFF: rdata_d = {3'b000, cfg_q.col_dc};
            COL_CTRL_OFF: rdata_d = {7'h00, col_ctrl_q};
            GLOBAL_OFFSET_OFF: rdata_d = {2'b00, cfg_q.global_offset};
            CAPTURE_MODE_OFF: rdata_d = {5'h00, clamp_busy, clamp_done_q, clamp_off_q};
            UPPER_REF_OFF: rdata_d = upper_ref_q;
            LOWER_REF_OFF: rdata_d = lower_ref_q;
            DEVICE_ID_OFF: rdata_d = DEVICE_ID;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 4; i++) begin
            cfg_q.colour_gain[i] <= COLOUR_GAIN_RST;
            cfg_q.col_addr[i] <= 6'h00;
            cfg_q.col_value[i] <= 4'h0;
         end
         cfg_q.global_gain <= GLOBAL_GAIN_RST;
         cfg_q.col_dc <= 5'h00;
         cfg_q.global_offset <= 6'h00;
         col_ctrl_q <= 1'b0;
         clamp_off_q <= 1'b0;
         upper_ref_q <= UPPER_REF_RST;
         lower_ref_q <= LOWER_REF_RST;
         rdata_q <= 8'h00;
      end else begin
         cfg_q <= cfg_d;
         col_ctrl_q <= col_ctrl_d;
         clamp_off_q <= clamp_off_d;
         upper_ref_q <= upper_ref_d;
         lower_ref_q <= lower_ref_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Frame-boundary shadow copy
   // ---------------------------------------------------------------
   // Copying only at frame start avoids a gain step appearing mid-image.
   shadow_set_t act_q, act_d;

   always_comb begin
      act_d = act_q;
      if (frame_start_i) begin
         act_d = cfg_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 4; i++) begin
            act_q.colour_gain[i] <= COLOUR_GAIN_RST;
            act_q.col_addr[i] <= 6'h00;
            act_q.col_value[i] <= 4'h0;
         end
         act_q.global_gain <= GLOBAL_GAIN_RST;
         act_q.col_dc <= 5'h00;
         act_q.global_offset <= 6'h00;
      end else begin
         act_q <= act_d;
      end
   end

   // ---------------------------------------------------------------
   // Black-level clamp sequencer
   // ---------------------------------------------------------------
   assign clamp_busy = (cl_state_q != CL_IDLE) && (cl_state_q != CL_DONE);

   always_comb begin
      cl_state_d = cl_state_q;
      dark_cnt_d = dark_cnt_q;
      clamp_done_d = clamp_done_q;
      case (cl_state_q)
         CL_IDLE, CL_DONE: begin
            if (frame_start_i && !clamp_off_q) begin
               cl_state_d = CL_SKIP;
               dark_cnt_d = 2'd0;
               clamp_done_d = 1'b0;
            end
         end
         CL_SKIP: begin
            if (row_start_i && dark_row_i) begin
               if (dark_cnt_q == 2'(DARK_ROWS_SKIPPED)) begin
                  cl_state_d = CL_SAMPLE;
               end else begin
                  dark_cnt_d = dark_cnt_q + 2'd1;
               end
            end else if (row_start_i) begin
               cl_state_d = CL_IDLE; // No usable dark row left this frame
            end
         end
         CL_SAMPLE: begin
            if (row_start_i || frame_start_i) begin
               cl_state_d = CL_DONE;
               clamp_done_d = 1'b1;
            end
         end
         default: cl_state_d = CL_IDLE;
      endcase
      // A new frame restarts the measurement, even mid-sequence, unless the clamp is switched off
      if (frame_start_i && !clamp_off_q) begin
         cl_state_d = CL_SKIP;
         dark_cnt_d = 2'd0;
         clamp_done_d = 1'b0;
      end
      if (clamp_off_q) begin
         cl_state_d = CL_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cl_state_q <= CL_IDLE;
         dark_cnt_q <= 2'd0;
         clamp_done_q <= 1'b0;
      end else begin
         cl_state_q <= cl_state_d;
         dark_cnt_q <= dark_cnt_d;
         clamp_done_q <= clamp_done_d;
      end
   end

   // Dark pixels of the sampled row are held; amplifier outputs go to common mode
   assign clamp_active_o = (cl_state_q == CL_SAMPLE);
   assign force_common_mode_o = (cl_state_q == CL_SAMPLE);

   // ---------------------------------------------------------------
   // Per-pixel control word
   // ---------------------------------------------------------------
   pixel_ctrl_t pix_q, pix_d;
   logic pix_vld_q, pix_vld_d;
   logic [1:0] colour_sel;
   logic [5:0] col_in_block;

   always_comb begin
      colour_sel = {row_blue_i, col_odd_i};
      col_in_block = col_i[5:0];
      pix_d = pix_q;
      pix_vld_d = pixel_valid_i;
      if (pixel_valid_i) begin
         pix_d.wb_gain = gain_setting(WB_GAIN_MIN, WB_GAIN_STEP, WB_GAIN_MAX,
                                      act_q.colour_gain[colour_sel]);
         pix_d.global_gain = gain_setting(GL_GAIN_MIN, GL_GAIN_STEP, GL_GAIN_MAX,
                                          act_q.global_gain);
         pix_d.global_offset = offset_value(act_q.global_offset);
         if (col_ctrl_q) begin
            pix_d.col_offset = 5'h00;
            for (int i = 0; i < COL_SLOTS; i++) begin
               if (col_in_block == act_q.col_addr[i]) begin
                  pix_d.col_offset = {1'b0, act_q.col_value[i]};
               end
            end
         end else begin
            pix_d.col_offset = act_q.col_dc;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pix_q <= '0;
         pix_vld_q <= 1'b0;
      end else begin
         pix_q <= pix_d;
         pix_vld_q <= pix_vld_d;
      end
   end

   assign pixel_valid_o = pix_vld_q;
   assign pixel_ctrl_o = pix_q;
   assign reg_rdata_o = rdata_q;
   assign upper_converter_reference_o = upper_ref_q;
   assign lower_converter_reference_o = lower_ref_q;
endmodule

// *** src/chain_ctrl_pkg.sv ***
package chain_ctrl_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] RED_GAIN_OFF = 8'h00;
   localparam logic [7:0] GREEN_ON_RED_ROW_GAIN_OFF = 8'h01;
   localparam logic [7:0] GREEN_ON_BLUE_ROW_GAIN_OFF = 8'h02;
   localparam logic [7:0] BLUE_GAIN_OFF = 8'h03;
   localparam logic [7:0] LOWER_REF_OFF = 8'h0a;
   localparam logic [7:0] UPPER_REF_OFF = 8'h0b;
   localparam logic [7:0] DEVICE_ID_OFF = 8'h0f;
   localparam logic [7:0] GLOBAL_GAIN_OFF = 8'h10;
   localparam logic [7:0] COL_DC_OFF = 8'h20;
   localparam logic [7:0] COL_CTRL_OFF = 8'h21;
   localparam logic [7:0] GLOBAL_OFFSET_OFF = 8'h22;
   localparam logic [7:0] COL_ADDR_BASE_OFF = 8'h23;
   localparam logic [7:0] COL_VALUE_BASE_OFF = 8'h27;
   localparam logic [7:0] CAPTURE_MODE_OFF = 8'h40;
   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [5:0] COLOUR_GAIN_RST = 6'h02;
   localparam logic [5:0] GLOBAL_GAIN_RST = 6'h00;
   localparam logic [7:0] LOWER_REF_RST = 8'h76;
   localparam logic [7:0] UPPER_REF_RST = 8'h80;
   localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5a;
   localparam int COL_CTRL_PERCOL_BIT = 0;
   localparam int CAPTURE_CLAMP_OFF_BIT = 0;
   localparam int OFFSET_SIGN_BIT = 5;
   // ---------------------------------------------------------------
   // Chain constants, gains in hundredths
   // ---------------------------------------------------------------
   localparam int COL_BLOCK = 64;
   localparam int COL_SLOTS = 4;
   localparam int DARK_ROWS_SKIPPED = 2;
   localparam logic [9:0] WB_GAIN_MIN = 10'd90;
   localparam logic [9:0] WB_GAIN_STEP = 10'd3;
   localparam logic [9:0] WB_GAIN_MAX = 10'd284;
   localparam logic [9:0] GL_GAIN_MIN = 10'd67;
   localparam logic [9:0] GL_GAIN_STEP = 10'd8;
   localparam logic [9:0] GL_GAIN_MAX = 10'd590;
   localparam int OFFSET_STAGE_GAIN = 2;

   typedef enum logic [3:0] {
      CL_IDLE = 4'b0001,
      CL_SKIP = 4'b0010,
      CL_SAMPLE = 4'b0100,
      CL_DONE = 4'b1000
   } clamp_state_t;

   typedef struct packed {
      logic [3:0][5:0] colour_gain;
      logic [5:0] global_gain;
      logic [4:0] col_dc;
      logic [5:0] global_offset;
      logic [3:0][5:0] col_addr;
      logic [3:0][3:0] col_value;
   } shadow_set_t;

   typedef struct packed {
      logic [9:0] wb_gain;
      logic [9:0] global_gain;
      logic [4:0] col_offset;
      logic signed [6:0] global_offset;
   } pixel_ctrl_t;
endpackage

// *** testbench/pixel_signal_chain_control_sva.sv ***
`timescale 1ns/100ps
module pixel_signal_chain_control_sva (
   input logic clk_i,
   input logic sys_rst_i,
   input logic reg_wr_i,
   input logic [7:0] reg_addr_i,
   input logic [7:0] reg_wdata_i,
   input logic frame_start_i,
   input logic row_start_i,
   input logic dark_row_i,
   input logic pixel_valid_o,
   input chain_ctrl_pkg::pixel_ctrl_t pixel_ctrl_o,
   input logic clamp_active_o,
   input logic force_common_mode_o,
   input logic [7:0] upper_converter_reference_o,
   input logic [7:0] lower_converter_reference_o
);
   import chain_ctrl_pkg::*;
   // ----
   // Shadow of clamp mode, rebuilt from the bus, and of dark row count, rebuilt from the row inputs
   // ----
   logic clamp_off_q, clamp_off_d;
   logic [1:0] dark_cnt_q, dark_cnt_d;
   always_comb begin
      clamp_off_d = clamp_off_q;
      dark_cnt_d = dark_cnt_q;
      if (reg_wr_i && reg_addr_i == CAPTURE_MODE_OFF) begin
         clamp_off_d = reg_wdata_i[CAPTURE_CLAMP_OFF_BIT];
      end
      if (frame_start_i || (row_start_i && !dark_row_i)) begin
         dark_cnt_d = 2'h0;
      end else if (row_start_i && dark_cnt_q != 2'h3) begin
         dark_cnt_d = dark_cnt_q + 2'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      clamp_off_q <= sys_rst_i ? 1'h0 : clamp_off_d;
      dark_cnt_q <= sys_rst_i ? 2'h0 : dark_cnt_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_rst_idle;
      disable iff (1'h0) sys_rst_i |=> !pixel_valid_o && !clamp_active_o;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
   property p_ref_dflt;
      disable iff (1'h0) sys_rst_i |=> upper_converter_reference_o == UPPER_REF_RST
         && lower_converter_reference_o == LOWER_REF_RST;
   endproperty
   a_ref_dflt: assert property (p_ref_dflt) else $error("reference codes not default");
   property p_cm;
      force_common_mode_o == clamp_active_o;
   endproperty
   a_cm: assert property (p_cm) else $error("common mode differs from clamp");
   property p_clamp_off;
      clamp_off_q |-> ##2 !clamp_active_o;
   endproperty
   a_clamp_off: assert property (p_clamp_off) else $error("clamp while disabled");
   property p_clamp_cause;
      $rose(clamp_active_o) |-> $past(row_start_i && dark_row_i);
   endproperty
   a_clamp_cause: assert property (p_clamp_cause) else $error("clamp without dark row");
   property p_clamp_third;
      $rose(clamp_active_o) |-> dark_cnt_q == 2'h3;
   endproperty
   a_clamp_third: assert property (p_clamp_third) else $error("clamp on wrong dark row");
   property p_clamp_drop;
      clamp_active_o && (row_start_i || frame_start_i) |=> !clamp_active_o;
   endproperty
   a_clamp_drop: assert property (p_clamp_drop) else $error("clamp held too long");
   property p_wb_range;
      pixel_valid_o |-> pixel_ctrl_o.wb_gain >= WB_GAIN_MIN && pixel_ctrl_o.wb_gain <= WB_GAIN_MAX
         && (pixel_ctrl_o.wb_gain - WB_GAIN_MIN) % WB_GAIN_STEP == 10'h0;
   endproperty
   a_wb_range: assert property (p_wb_range) else $error("colour gain off grid");
   property p_gl_range;
      pixel_valid_o |-> pixel_ctrl_o.global_gain >= GL_GAIN_MIN
         && (pixel_ctrl_o.global_gain - GL_GAIN_MIN) % GL_GAIN_STEP == 10'h0;
   endproperty
   a_gl_range: assert property (p_gl_range) else $error("global gain off grid");
   property p_off_even;
      pixel_valid_o |-> !pixel_ctrl_o.global_offset[0];
   endproperty
   a_off_even: assert property (p_off_even) else $error("offset lacks double gain");
   c_clamp: cover property ($rose(clamp_active_o));
   c_percol: cover property (pixel_valid_o && pixel_ctrl_o.col_offset != 5'h0);
   c_off_frame: cover property (clamp_off_q && frame_start_i);
endmodule
bind pixel_signal_chain_control pixel_signal_chain_control_sva sva (.*);

// *** testbench/reg_host_model.sv ***
`timescale 1ns/100ps
module reg_host_model (
   input logic clk_i,
   input logic sys_rst_i,
   input logic [7:0] rdata_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   // ----
   // Host side: idle address and data toggle so stale values never pass
   // ----
   initial begin
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] rd);
      while (sys_rst_i) @(posedge clk_i);
      @(posedge clk_i);
      #1;
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {wr, !wr, a, d};
      @(posedge clk_i);
      #1;
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'h0, ~a, ~d};
      rd = rdata_i;
   endtask
endmodule

// *** testbench/pixel_signal_chain_control_tb_top.sv ***
`timescale 1ns/100ps
module pixel_signal_chain_control_tb_top;
   import chain_ctrl_pkg::*;
   logic clk_i, sys_rst_i, frame_start_i, row_start_i, dark_row_i, pixel_valid_i;
   logic row_blue_i, col_odd_i, pixel_valid_o, clamp_active_o, force_common_mode_o;
   logic reg_wr_i, reg_rd_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
   logic [7:0] upper_converter_reference_o, lower_converter_reference_o;
   logic [8:0] col_i;
   pixel_ctrl_t pixel_ctrl_o;
   int miscompares = 0;
   int checks = 0;
   // ----
   // Rows: colour gain code beside the expected gain in hundredths
   // ----
   logic [15:0] rows [4] = '{{6'h00, 10'h05a}, {6'h05, 10'h069}, {6'h3f, 10'h117},
      {6'h10, 10'h08a}};
   reg_host_model host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rdata_i(reg_rdata_o),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i));
   pixel_signal_chain_control dut (.*);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      host.xfer(1'h1, a, d, rd);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      host.xfer(1'h0, a, 8'h00, rd);
      chk(what, rd, exp);
   endtask
   // Control bits are frame, row, dark, pixel; one cycle each
   task automatic drv(input logic [3:0] ctl, input logic [1:0] clr, input logic [8:0] col);
      @(posedge clk_i);
      #1;
      {frame_start_i, row_start_i, dark_row_i, pixel_valid_i} = ctl;
      {row_blue_i, col_odd_i} = clr;
      col_i = col;
      @(posedge clk_i);
      #1;
      {frame_start_i, row_start_i, dark_row_i, pixel_valid_i} = 4'h0;
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'h0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      #250000;
      miscompares++;
      wrap_up();
   end
   initial begin
      sys_rst_i = 1'h1;
      {frame_start_i, row_start_i, dark_row_i, pixel_valid_i, row_blue_i, col_odd_i} = 6'h0;
      col_i = 9'h000;
      repeat (12) @(posedge clk_i);
      #1;
      sys_rst_i = 1'h0;
      rdchk(RED_GAIN_OFF, 8'h02, "red_gain");
      rdchk(BLUE_GAIN_OFF, 8'h02, "blue_gain");
      chk("upper_ref", upper_converter_reference_o, 8'h80);
      chk("lower_ref", lower_converter_reference_o, 8'h76);
      rdchk(8'h30, 8'h00, "unmapped");
      rdchk(DEVICE_ID_OFF, DEVICE_ID_DEFAULT, "device_id");
      $display("test defaults done");
      for (int i = 0; i < 4; i++) wr(i[7:0], {2'h0, rows[i][15:10]});
      wr(GLOBAL_GAIN_OFF, 8'h3f);
      wr(GLOBAL_OFFSET_OFF, 8'h25);
      wr(COL_DC_OFF, 8'h1f);
      drv(4'h1, 2'h0, 9'h005);
      chk("wb_before_frame", pixel_ctrl_o.wb_gain, 10'd96);
      drv(4'h8, 2'h0, 9'h000);
      for (int i = 0; i < 4; i++) begin
         drv(4'h1, i[1:0], 9'(i * 67));
         chk("pixel_valid", pixel_valid_o, 1'h1);
         chk("wb_gain", pixel_ctrl_o.wb_gain, rows[i][9:0]);
         chk("global_gain", pixel_ctrl_o.global_gain, 10'h23b);
         chk("global_offset", $unsigned(pixel_ctrl_o.global_offset), 7'h76);
         chk("col_dc", pixel_ctrl_o.col_offset, 5'h1f);
      end
      $display("test gain rows done");
      wr(RED_GAIN_OFF, 8'h0a);
      drv(4'h1, 2'h0, 9'h000);
      chk("wb_mid_frame", pixel_ctrl_o.wb_gain, 10'h05a);
      wr(COL_CTRL_OFF, 8'h01);
      wr(COL_ADDR_BASE_OFF, 8'h05);
      wr(COL_VALUE_BASE_OFF, 8'h09);
      wr(COL_ADDR_BASE_OFF + 8'h03, 8'h3f);
      wr(COL_VALUE_BASE_OFF + 8'h03, 8'h07);
      drv(4'h8, 2'h0, 9'h000);
      drv(4'h1, 2'h0, 9'd197);
      chk("wb_new_frame", pixel_ctrl_o.wb_gain, 10'h078);
      chk("col_slot1", pixel_ctrl_o.col_offset, 5'h09);
      drv(4'h1, 2'h0, 9'd191);
      chk("col_slot4", pixel_ctrl_o.col_offset, 5'h07);
      drv(4'h1, 2'h0, 9'd6);
      chk("col_nomatch", pixel_ctrl_o.col_offset, 5'h00);
      $display("test column correction done");
      for (int m = 0; m < 3; m++) begin
         wr(CAPTURE_MODE_OFF, {7'h00, m == 2});
         drv(4'h8, 2'h0, 9'h000);
         repeat (2) drv(4'h6, 2'h0, 9'h000);
         chk("early_clamp", clamp_active_o, 1'h0);
         drv(4'h6, 2'h0, 9'h000);
         chk("clamp_active", clamp_active_o, m != 2);
         chk("common_mode", force_common_mode_o, m != 2);
         drv(4'h4, 2'h0, 9'h000);
         chk("clamp_drop", clamp_active_o, 1'h0);
      end
      rdchk(CAPTURE_MODE_OFF, 8'h03, "capture_status");
      $display("test clamp done");
      wr(UPPER_REF_OFF, 8'h40);
      chk("upper_written", upper_converter_reference_o, 8'h40);
      @(posedge clk_i);
      #1;
      sys_rst_i = 1'h1;
      pixel_valid_i = 1'h1;
      repeat (2) @(posedge clk_i);
      #1;
      chk("valid_in_reset", pixel_valid_o, 1'h0);
      chk("ctrl_in_reset", pixel_ctrl_o, 32'h0);
      {sys_rst_i, pixel_valid_i} = 2'h0;
      chk("upper_reset", upper_converter_reference_o, 8'h80);
      rdchk(RED_GAIN_OFF, 8'h02, "red_after_reset");
      rdchk(COL_CTRL_OFF, 8'h00, "col_ctrl_after_reset");
      $display("test mid run reset done");
      wrap_up();
   end
endmodule
